// File: rtl/input_overvoltage_fault_handler.sv
// input overvoltage fault detection, response and retry sequencing
//
// Contract
// [R1] A 16-bit linear-format trip level is held and any input voltage above it is a fault.
// [R2] Response 00 ignores the fault and leaves the output running.
// [R3] Response 01 keeps running for the delay time, then applies the retry setting if the fault is still there.
// [R4] Response 10 disables the output at once and then follows the retry setting.
// [R5] Response 11 disables the output and holds it off until the fault is cleared.
// [R6] A latched fault clears on a status clear, a clear-faults command, reset, or an off-then-on command.
// [R7] Retry setting 000 makes no restart attempt and leaves the output off until cleared.
// [R8] Retry setting 001 makes exactly one restart attempt.
// [R9] Retry setting 010 makes exactly two restart attempts.
// [R10] When all restart attempts fail the output stays off until the fault is cleared.
// [R11] Restart attempts are spaced by the delay count times the delay unit.
// [R12] Delay codes 0 to 7 select 1, 2, 4, 8, 16, 32, 64 or 128 delay units.
// [R13] Retry settings 011 to 110 give three to six attempts and 111 retries without limit.
// [R14] The fault status bit sets whenever the trip comparison fires, whatever the response.
`timescale 1ns/1ps
`default_nettype none
module input_overvoltage_fault_handler (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_unmapped,
    input wire logic [15:0] vin_measured,
    input wire logic unit_tick,
    input wire logic control_pin,
    input wire logic operation_on,
    input wire logic clear_status,
    input wire logic clear_faults,
    output logic output_enable,
    output logic fault_status,
    output logic fault_latched
);
    // =========================================================
    // helpers
    function automatic logic signed [ovf_pkg::FIX_W-1:0] linear_to_fixed(
        input logic [15:0] word
    );
        logic signed [4:0] expo;
        logic signed [ovf_pkg::FIX_W-1:0] mant;
        expo = $signed(word[ovf_pkg::EXP_HI:ovf_pkg::EXP_LO]);
        mant = ovf_pkg::FIX_W'($signed(word[ovf_pkg::MANT_HI:ovf_pkg::MANT_LO]));
        linear_to_fixed = mant <<< (6'(expo) + 6'(ovf_pkg::FIX_FRAC));
    endfunction : linear_to_fixed
    function automatic logic [7:0] delay_units(input logic [2:0] code);
        delay_units = 8'h01 << code; // [R12]
    endfunction : delay_units
    // =========================================================
    // control pin synchroniser
    logic ctl_meta_reg;
    logic ctl_sync_reg;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctl_meta_reg <= 1'b0;
            ctl_sync_reg <= 1'b0;
        end else begin
            ctl_meta_reg <= control_pin;
            ctl_sync_reg <= ctl_meta_reg;
        end
    end

    // =========================================================
    // registers
    logic [15:0] trip_level_reg;
    logic [15:0] trip_level_next;
    logic [7:0] action_reg;
    logic [7:0] action_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic unmapped_reg;
    logic unmapped_next;
    always_comb begin
        trip_level_next = trip_level_reg;
        action_next = action_reg;
        rdata_next = rdata_reg;
        unmapped_next = 1'b0;
        if (cmd_valid) begin
            unique case (cmd_code)
                ovf_pkg::CMD_TRIP_LEVEL: begin
                    if (cmd_write) begin
                        trip_level_next = cmd_wdata; // [R1]
                    end else begin
                        rdata_next = trip_level_reg;
                    end
                end
                ovf_pkg::CMD_FAULT_ACTION: begin
                    if (cmd_write) begin
                        action_next = cmd_wdata[7:0];
                    end else begin
                        rdata_next = {8'h00, action_reg};
                    end
                end
                default: begin
                    unmapped_next = 1'b1;
                    if (!cmd_write) begin
                        rdata_next = 16'h0000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trip_level_reg <= ovf_pkg::TRIP_LEVEL_RESET;
            action_reg <= ovf_pkg::FAULT_ACTION_RESET;
            rdata_reg <= 16'h0000;
            unmapped_reg <= 1'b0;
        end else begin
            trip_level_reg <= trip_level_next;
            action_reg <= action_next;
            rdata_reg <= rdata_next;
            unmapped_reg <= unmapped_next;
        end
    end
    assign cmd_rdata = rdata_reg;
    assign cmd_unmapped = unmapped_reg;

    // =========================================================
    // fault detection and clearing
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay_code;
    logic over;
    logic cmd_on;
    logic clear_evt;
    assign resp = action_reg[ovf_pkg::RESP_HI:ovf_pkg::RESP_LO];
    assign retry = action_reg[ovf_pkg::RETRY_HI:ovf_pkg::RETRY_LO];
    assign delay_code = action_reg[ovf_pkg::DELAY_HI:ovf_pkg::DELAY_LO];
    assign over = linear_to_fixed(vin_measured) > linear_to_fixed(trip_level_reg); // [R1]
    assign cmd_on = ctl_sync_reg && operation_on;
    // being commanded off clears; the output returns when commanded back on
    assign clear_evt = clear_status || clear_faults || !cmd_on; // [R6]
    logic status_reg;
    logic status_next;
    always_comb begin
        status_next = status_reg;
        if (clear_status || clear_faults) begin
            status_next = 1'b0;
        end
        if (over) begin
            status_next = 1'b1; // [R14]
        end
    end

    // =========================================================
    // response sequencer
    ovf_pkg::fault_state_t state_reg;
    ovf_pkg::fault_state_t state_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [2:0] attempts_reg;
    logic [2:0] attempts_next;
    logic wait_done;
    assign wait_done = unit_tick && (cnt_reg + 8'h01 >= delay_units(delay_code)); // [R11]
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        attempts_next = attempts_reg;
        if (clear_evt) begin
            state_next = ovf_pkg::st_run; // [R6]
            cnt_next = 8'h00;
        end else begin
            unique case (state_reg)
                ovf_pkg::st_run: begin
                    cnt_next = 8'h00;
                    attempts_next = retry;
                    if (over) begin
                        unique case (resp)
                            ovf_pkg::RESP_IGNORE: state_next = ovf_pkg::st_run; // [R2]
                            ovf_pkg::RESP_DELAY_THEN_RETRY: state_next = ovf_pkg::st_delay; // [R3]
                            ovf_pkg::RESP_DISABLE_RETRY: begin
                                state_next = (retry == ovf_pkg::RETRY_NONE) ? // [R4] [R7]
                                    ovf_pkg::st_latched : ovf_pkg::st_off_wait;
                            end
                            ovf_pkg::RESP_DISABLE_LATCH: state_next = ovf_pkg::st_latched; // [R5]
                        endcase
                    end
                end
                ovf_pkg::st_delay: begin
                    if (unit_tick) begin
                        cnt_next = cnt_reg + 8'h01;
                    end
                    if (wait_done) begin
                        cnt_next = 8'h00;
                        if (!over) begin
                            state_next = ovf_pkg::st_run;
                        end else if (retry == ovf_pkg::RETRY_NONE) begin
                            state_next = ovf_pkg::st_latched; // [R3] [R7]
                        end else begin
                            state_next = ovf_pkg::st_off_wait; // [R3]
                        end
                    end
                end
                ovf_pkg::st_off_wait: begin
                    if (unit_tick) begin
                        cnt_next = cnt_reg + 8'h01;
                    end
                    if (wait_done) begin
                        cnt_next = 8'h00;
                        if (!over) begin
                            state_next = ovf_pkg::st_run; // restart succeeded
                        end else if (retry == ovf_pkg::RETRY_FOREVER) begin
                            state_next = ovf_pkg::st_off_wait; // [R13]
                        end else if (attempts_reg == ovf_pkg::RETRY_ONCE) begin
                            state_next = ovf_pkg::st_latched; // [R8] [R9] [R10]
                        end else begin
                            attempts_next = attempts_reg - 3'h1; // [R13]
                        end
                    end
                end
                ovf_pkg::st_latched: begin
                    state_next = ovf_pkg::st_latched; // [R5] [R10]
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ovf_pkg::st_run; // [R6]
            cnt_reg <= 8'h00;
            attempts_reg <= 3'h0;
            status_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            attempts_reg <= attempts_next;
            status_reg <= status_next;
        end
    end
    assign output_enable = cmd_on && (state_reg == ovf_pkg::st_run
        || state_reg == ovf_pkg::st_delay);
    assign fault_status = status_reg;
    assign fault_latched = (state_reg == ovf_pkg::st_latched);

    // =========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_status_set;
        over |=> fault_status;
    endproperty
    a_status_set: assert property (p_status_set) else $error("status not set"); // [R14]
    property p_ignore;
        state_reg == ovf_pkg::st_run && resp == ovf_pkg::RESP_IGNORE && over && !clear_evt
            |=> state_reg == ovf_pkg::st_run;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored fault disturbed output"); // [R2]
    property p_delay_runs;
        state_reg == ovf_pkg::st_delay && cmd_on |-> output_enable;
    endproperty
    a_delay_runs: assert property (p_delay_runs) else $error("output off during delay"); // [R3]
    property p_disable_now;
        state_reg == ovf_pkg::st_run && over && resp[1] && !clear_evt ##1 !clear_evt
            |-> !output_enable;
    endproperty
    a_disable_now: assert property (p_disable_now) else $error("output not disabled"); // [R4]
    property p_latch;
        state_reg == ovf_pkg::st_run && over && resp == ovf_pkg::RESP_DISABLE_LATCH
            && !clear_evt |=> fault_latched;
    endproperty
    a_latch: assert property (p_latch) else $error("fault not latched"); // [R5]
    property p_clear;
        clear_faults |=> !fault_latched;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored"); // [R6]
    property p_no_retry;
        state_reg == ovf_pkg::st_run && over && resp == ovf_pkg::RESP_DISABLE_RETRY
            && retry == ovf_pkg::RETRY_NONE && !clear_evt |=> fault_latched;
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("retried with setting 000"); // [R7]
    property p_latched_off;
        fault_latched |-> !output_enable;
    endproperty
    a_latched_off: assert property (p_latched_off) else $error("latched but on"); // [R10]
    property p_spacing;
        state_reg == ovf_pkg::st_off_wait && !unit_tick && !clear_evt
            |=> state_reg == ovf_pkg::st_off_wait;
    endproperty
    a_spacing: assert property (p_spacing) else $error("restart without unit tick"); // [R11]
    property p_forever;
        state_reg == ovf_pkg::st_off_wait && retry == ovf_pkg::RETRY_FOREVER && !clear_evt
            |=> !fault_latched;
    endproperty
    a_forever: assert property (p_forever) else $error("continuous retry gave up"); // [R13]
    c_ignore: cover property (state_reg == ovf_pkg::st_run && over && resp == ovf_pkg::RESP_IGNORE);
    c_delay: cover property (state_reg == ovf_pkg::st_delay ##1 state_reg == ovf_pkg::st_off_wait);
    c_restart: cover property (state_reg == ovf_pkg::st_off_wait ##1 state_reg == ovf_pkg::st_run);
    c_exhaust: cover property (state_reg == ovf_pkg::st_off_wait ##1 fault_latched);
endmodule : input_overvoltage_fault_handler
`default_nettype wire

// File: shared/ovf_pkg.sv
// constants and types for the input overvoltage fault handler
package ovf_pkg;
    // =========================================================
    // command codes
    localparam logic [7:0] CMD_TRIP_LEVEL = 8'h55;
    localparam logic [7:0] CMD_FAULT_ACTION = 8'h56;
    // =========================================================
    // reset values
    localparam logic [15:0] TRIP_LEVEL_RESET = 16'h0000;
    localparam logic [7:0] FAULT_ACTION_RESET = 8'hc0;
    // =========================================================
    // action register fields
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_DELAY_THEN_RETRY = 2'h1;
    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] RESP_DISABLE_LATCH = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ONCE = 3'h1;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // =========================================================
    // linear format fields
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MANT_HI = 10;
    localparam int MANT_LO = 0;
    localparam int FIX_FRAC = 16;
    localparam int FIX_W = 48;
    // =========================================================
    // handler states
    typedef enum logic [1:0] {
        st_run,
        st_delay,
        st_off_wait,
        st_latched
    } fault_state_t;
endpackage : ovf_pkg

// File: verif/ovf_host.sv
// host model issuing management commands to the fault handler
`timescale 1ns/1ps
`default_nettype none
module ovf_host (
    input wire logic clock,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_unmapped
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // =========================================================
    // one command; fields scrambled once released
    task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
        cmd_wdata <= ~d;
    endtask : send
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic u);
        send(1'b0, c, 16'h0000);
        // read data stands from the taking edge on
        @(posedge clock);
        d = cmd_rdata;
        u = cmd_unmapped;
    endtask : rd
endmodule : ovf_host
`default_nettype wire

// File: verif/input_overvoltage_fault_handler_tb.sv
// testbench for the input overvoltage fault handler
`timescale 1ns/1ps
`default_nettype none
module input_overvoltage_fault_handler_tb;
    // =========================================================
    // stimulus and observation
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata;
    logic [15:0] cmd_rdata;
    logic cmd_unmapped;
    logic [15:0] vin_measured = 16'h0000;
    logic unit_tick = 1'b0;
    logic control_pin = 1'b1;
    logic operation_on = 1'b1;
    logic clear_status = 1'b0;
    logic clear_faults = 1'b0;
    logic output_enable;
    logic fault_status;
    logic fault_latched;
    logic [15:0] rv;
    logic ru;
    int err_count = 0;
    int total_checks = 0;
    always #2 clock = ~clock;
    always @(posedge clock) unit_tick <= ~unit_tick;
    ovf_host u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_unmapped(cmd_unmapped));
    input_overvoltage_fault_handler u_dut (.clock(clock), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_unmapped(cmd_unmapped),
        .vin_measured(vin_measured), .unit_tick(unit_tick), .control_pin(control_pin),
        .operation_on(operation_on), .clear_status(clear_status),
        .clear_faults(clear_faults), .output_enable(output_enable),
        .fault_status(fault_status), .fault_latched(fault_latched));
    // =========================================================
    // compares and verdict
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rng(input string n, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : rng
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // =========================================================
    // helpers
    task automatic clear_go(input int how);
        vin_measured <= 16'h0028;
        @(posedge clock);
        case (how)
            0: clear_status <= 1'b1;
            1: clear_faults <= 1'b1;
            2: operation_on <= 1'b0;
            default: control_pin <= 1'b0;
        endcase
        @(posedge clock);
        clear_status <= 1'b0;
        clear_faults <= 1'b0;
        repeat (3) @(posedge clock);
        operation_on <= 1'b1;
        control_pin <= 1'b1;
        repeat (5) @(posedge clock);
    endtask : clear_go
    task automatic run_fault(input logic [7:0] a, input int lo, input int hi, input int dl,
        input int dh);
        int n;
        int drop;
        u_host.send(1'b1, ovf_pkg::CMD_FAULT_ACTION, {8'h00, a});
        vin_measured <= 16'h0032;
        n = 0;
        drop = 0;
        while (fault_latched !== 1'b1) begin
            @(posedge clock);
            n++;
            if (drop == 0 && output_enable !== 1'b1) drop = n;
            if (n > 2000) begin
                err_count++;
                give_verdict();
            end
        end
        rng("cycles to latch", lo, hi, n);
        rng("cycles to off", dl, dh, drop);
        chk("status", 16'h0001, {15'h0, fault_status});
        clear_go(1);
        chk("on after clear", 16'h0001, {15'h0, output_enable});
    endtask : run_fault
    // =========================================================
    // scenarios
    task automatic t_regs;
        u_host.rd(ovf_pkg::CMD_TRIP_LEVEL, rv, ru);
        chk("level reset", 16'h0000, rv);
        chk("unmapped", 16'h0000, {15'h0, ru});
        u_host.rd(ovf_pkg::CMD_FAULT_ACTION, rv, ru);
        chk("action reset", 16'h00c0, rv);
        u_host.send(1'b1, ovf_pkg::CMD_FAULT_ACTION, 16'habcd);
        u_host.rd(ovf_pkg::CMD_FAULT_ACTION, rv, ru);
        chk("action", 16'h00cd, rv);
        u_host.rd(8'h57, rv, ru);
        chk("unknown read", 16'h0000, rv);
        chk("unknown flag", 16'h0001, {15'h0, ru});
    endtask : t_regs
    task automatic t_format;
        logic [15:0] lv [4] = '{16'h0818, 16'h0818, 16'hf860, 16'hf860};
        logic [15:0] vv [4] = '{16'h0031, 16'h002f, 16'h0030, 16'hf862};
        logic ex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        u_host.send(1'b1, ovf_pkg::CMD_FAULT_ACTION, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            u_host.send(1'b1, ovf_pkg::CMD_TRIP_LEVEL, lv[i]);
            clear_go(0);
            u_host.rd(ovf_pkg::CMD_TRIP_LEVEL, rv, ru);
            chk("level", lv[i], rv);
            vin_measured <= vv[i];
            repeat (4) @(posedge clock);
            chk("trip", {15'h0, ex[i]}, {15'h0, fault_status});
            chk("ignored", 16'h0001, {15'h0, output_enable});
        end
        clear_go(0);
        chk("status cleared", 16'h0000, {15'h0, fault_status});
        u_host.send(1'b1, ovf_pkg::CMD_TRIP_LEVEL, 16'h0030);
    endtask : t_format
    task automatic t_retry;
        for (int d = 0; d < 8; d++) begin
            run_fault({5'h08, d[2:0]}, 2 << d, (2 << d) + 6, 2 << d, (2 << d) + 6);
        end
        for (int r = 1; r < 7; r++) begin
            run_fault({2'h2, r[2:0], 3'h3}, 16 * r, 16 * r + 12, 1, 3);
        end
        run_fault(8'hc0, 1, 3, 1, 3);
        run_fault(8'h80, 1, 3, 1, 3);
        run_fault(8'h48, 5, 6, 3, 4);
    endtask : t_retry
    task automatic t_clear;
        for (int h = 0; h < 4; h++) begin
            run_fault(8'hc0, 1, 3, 1, 3);
            run_fault(8'hc0, 1, 3, 1, 3);
            u_host.send(1'b1, ovf_pkg::CMD_FAULT_ACTION, 16'h00c0);
            vin_measured <= 16'h0032;
            repeat (4) @(posedge clock);
            vin_measured <= 16'h0028;
            repeat (10) @(posedge clock);
            chk("held off", 16'h0000, {15'h0, output_enable});
            clear_go(h);
            chk("cleared", 16'h0000, {15'h0, fault_latched});
            chk("back on", 16'h0001, {15'h0, output_enable});
        end
    endtask : t_clear
    task automatic t_recover(input logic [7:0] a, input int wait_n);
        u_host.send(1'b1, ovf_pkg::CMD_FAULT_ACTION, {8'h00, a});
        vin_measured <= 16'h0032;
        repeat (wait_n) @(posedge clock);
        chk("off in fault", 16'h0000, {15'h0, output_enable});
        chk("not latched", 16'h0000, {15'h0, fault_latched});
        vin_measured <= 16'h0028;
        repeat (24) @(posedge clock);
        chk("restarted", 16'h0001, {15'h0, output_enable});
        clear_go(1);
    endtask : t_recover
    task automatic t_reset;
        u_host.send(1'b1, ovf_pkg::CMD_FAULT_ACTION, 16'h00c0);
        vin_measured <= 16'h0032;
        repeat (4) @(posedge clock);
        chk("latched before reset", 16'h0001, {15'h0, fault_latched});
        vin_measured <= 16'h0000;
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        u_host.rd(ovf_pkg::CMD_FAULT_ACTION, rv, ru);
        chk("action after reset", 16'h00c0, rv);
        chk("latch after reset", 16'h0000, {15'h0, fault_latched});
        chk("status after reset", 16'h0000, {15'h0, fault_status});
        chk("on after reset", 16'h0001, {15'h0, output_enable});
        u_host.rd(ovf_pkg::CMD_TRIP_LEVEL, rv, ru);
        chk("level after reset", 16'h0000, rv);
    endtask : t_reset
    // =========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        t_regs();
        t_format();
        t_retry();
        t_clear();
        t_recover(8'h8b, 5);
        t_recover(8'hb8, 300);
        t_reset();
        give_verdict();
    end
endmodule : input_overvoltage_fault_handler_tb
`default_nettype wire
